// [tweei_core.sv]
// Slave protocol engine, page buffer, array and rewrite timer.
`timescale 1ns/1ns
module tweei_core #(
  parameter int         ADDR_W      = 8,
  parameter int         PAGE_W      = 5,
  parameter int         REWRITE_CYC = tweei_pkg::REWRITE_CYCLES,
  parameter logic [3:0] TYPE_CODE   = tweei_pkg::TYPE_CODE_DFLT
) (
  // System clock, reset and freeze.
  input  wire logic mclk_in,
  input  wire logic rstn_in,
  input  wire logic ce_in,
  // Link sampling clock.
  input  wire logic link_clk_in,
  // Two-wire pins.
  input  wire logic scl_in,
  input  wire logic sda_in,
  output wire logic sda_out,
  output wire logic sda_oe_out,
  // Strapped select pins.
  input  wire logic chip_select_bit2_in,
  input  wire logic chip_select_bit1_in,
  input  wire logic chip_select_bit0_in,
  // Rewrite status.
  output wire logic busy_out
);
  localparam int PAGE = 2 ** PAGE_W;
  localparam int CW   = $clog2(REWRITE_CYC + 1);

  // ----------------------------------------------------------------------
  // Link domain synchronisers
  // ----------------------------------------------------------------------
  logic [1:0]            lrst_ff;
  logic                  ce_s1_ff;
  logic                  ce_s2_ff;
  tweei_pkg::tweei_pins_t pin_s1_ff;
  tweei_pkg::tweei_pins_t pin_s2_ff;
  tweei_pkg::tweei_pins_t pin_d_ff;
  logic [2:0]            sel_s1_ff;
  logic [2:0]            sel_s2_ff;
  logic                  done_s1_ff;
  logic                  done_s2_ff;
  logic                  done_d_ff;
  logic                  done_tgl_ff;
  logic                  lrst_n;
  logic                  lce;

  // Release of the link reset is synchronised so no flop sees it mid-edge.
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lrst_ff <= 2'h0;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'h1};
    end
  end
  assign lrst_n = lrst_ff[1];

  // The freeze level crosses from the system domain by two flops.
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ce_s1_ff <= 1'h0;
      ce_s2_ff <= 1'h0;
    end else begin
      ce_s1_ff <= ce_in;
      ce_s2_ff <= ce_s1_ff;
    end
  end
  assign lce = ce_s2_ff;

  // Pins, straps and the done toggle pass two flops before any logic.
  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      pin_s1_ff  <= 2'h3;
      pin_s2_ff  <= 2'h3;
      pin_d_ff   <= 2'h3;
      sel_s1_ff  <= 3'h0;
      sel_s2_ff  <= 3'h0;
      done_s1_ff <= 1'h0;
      done_s2_ff <= 1'h0;
      done_d_ff  <= 1'h0;
    end else if (lce) begin
      pin_s1_ff  <= {scl_in, sda_in};
      pin_s2_ff  <= pin_s1_ff;
      pin_d_ff   <= pin_s2_ff;
      sel_s1_ff  <= {chip_select_bit2_in, chip_select_bit1_in,
                     chip_select_bit0_in};
      sel_s2_ff  <= sel_s1_ff;
      done_s1_ff <= done_tgl_ff;
      done_s2_ff <= done_s1_ff;
      done_d_ff  <= done_s2_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Line events
  // ----------------------------------------------------------------------
  tweei_pkg::tweei_state_t st_ff;
  logic [3:0]            cnt_ff;
  logic                  ack_ph_ff;
  logic [7:0]            sh_ff;
  logic [ADDR_W-1:0]     addr_ff;
  logic                  oe_ff;
  logic                  hack_ff;
  logic                  wrote_ff;
  logic                  pend_ff;
  logic                  req_tgl_ff;
  logic [7:0]            mem_ff [2**ADDR_W];
  logic [7:0]            pbuf_ff [PAGE];
  logic [PAGE-1:0]       pval_ff;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic bit_rise, byte_end, slot_end, ack_rise;
  logic match, give_ack, done_edge;
  logic [ADDR_W-1:0]     addr_inc;

  // Device word decode: type in the top nibble, then the select bits.
  function automatic logic dev_match(input logic [7:0] w,
                                     input logic [2:0] s);
    return (w[7:tweei_pkg::TYPE_LSB] == TYPE_CODE) &&
           (w[tweei_pkg::TYPE_LSB-1:tweei_pkg::SEL_LSB] == s);
  endfunction

  assign start_det = pin_s2_ff.scl & pin_d_ff.scl &
                     pin_d_ff.sda & ~pin_s2_ff.sda;
  assign stop_det  = pin_s2_ff.scl & pin_d_ff.scl &
                     ~pin_d_ff.sda & pin_s2_ff.sda;
  assign scl_rise  = pin_s2_ff.scl & ~pin_d_ff.scl;
  assign scl_fall  = ~pin_s2_ff.scl & pin_d_ff.scl;
  assign bit_rise  = scl_rise & ~ack_ph_ff & (cnt_ff != tweei_pkg::BIT_LAST);
  assign byte_end  = scl_fall & ~ack_ph_ff & (cnt_ff == tweei_pkg::BIT_LAST);
  assign slot_end  = scl_fall & ack_ph_ff;
  assign ack_rise  = scl_rise & ack_ph_ff;
  assign match     = dev_match(sh_ff, sel_s2_ff);
  assign done_edge = done_s2_ff ^ done_d_ff;
  // wraps to 0 past the last address.
  assign addr_inc  = addr_ff + 1'h1;
  // busy memory answers the address word with 1.
  assign give_ack  = ((st_ff == tweei_pkg::ST_DEVADR) && match && !pend_ff) ||
                     (st_ff == tweei_pkg::ST_MEMADR) ||
                     (st_ff == tweei_pkg::ST_WRDATA);

  // ----------------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------------
  // Drive changes only on a clock fall, so the line is stable while high.
  // drive on fall.
  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      st_ff     <= tweei_pkg::ST_IDLE;
      cnt_ff    <= 4'h0;
      ack_ph_ff <= 1'h0;
      sh_ff     <= 8'h00;
      addr_ff   <= '0;
      oe_ff     <= 1'h0;
      hack_ff   <= 1'h0;
    end else if (lce) begin
      if (start_det) begin
        st_ff     <= tweei_pkg::ST_DEVADR;
        cnt_ff    <= 4'h0;
        ack_ph_ff <= 1'h0;
        oe_ff     <= 1'h0;
      end else if (stop_det) begin
        st_ff     <= tweei_pkg::ST_IDLE;
        ack_ph_ff <= 1'h0;
        oe_ff     <= 1'h0;
      end else if (st_ff != tweei_pkg::ST_IDLE &&
                   st_ff != tweei_pkg::ST_IGNORE) begin
        if (bit_rise) begin
          if (st_ff != tweei_pkg::ST_RDDATA) begin
            sh_ff <= {sh_ff[6:0], pin_s2_ff.sda};
          end
          cnt_ff <= cnt_ff + 4'h1;
        end
        if (byte_end) begin
          ack_ph_ff <= 1'h1;
          // transmitter releases for the ninth clock.
          oe_ff     <= give_ack;
          // foreign type or select, or busy, is ignored.
          if (st_ff == tweei_pkg::ST_DEVADR && !give_ack) begin
            st_ff <= tweei_pkg::ST_IGNORE;
          end
        end
        if (ack_rise && st_ff == tweei_pkg::ST_RDDATA) begin
          hack_ff <= ~pin_s2_ff.sda;
        end
        if (scl_fall && !ack_ph_ff && cnt_ff != tweei_pkg::BIT_LAST &&
            st_ff == tweei_pkg::ST_RDDATA) begin
          sh_ff <= {sh_ff[6:0], 1'h1};
          oe_ff <= ~sh_ff[6];
        end
        if (slot_end) begin
          ack_ph_ff <= 1'h0;
          cnt_ff    <= 4'h0;
          oe_ff     <= 1'h0;
          unique case (st_ff)
            tweei_pkg::ST_DEVADR: begin
              if (sh_ff[tweei_pkg::RW_POS]) begin
                st_ff <= tweei_pkg::ST_RDDATA;
                sh_ff <= mem_ff[addr_ff];
                oe_ff <= ~mem_ff[addr_ff][7];
              end else begin
                st_ff <= tweei_pkg::ST_MEMADR;
              end
            end
            tweei_pkg::ST_MEMADR: begin
              addr_ff <= sh_ff[ADDR_W-1:0];
              st_ff   <= tweei_pkg::ST_WRDATA;
            end
            tweei_pkg::ST_WRDATA: begin
              addr_ff[PAGE_W-1:0] <= addr_ff[PAGE_W-1:0] + 1'h1;
            end
            tweei_pkg::ST_RDDATA: begin
              if (hack_ff) begin
                addr_ff <= addr_inc;
                sh_ff   <= mem_ff[addr_inc];
                oe_ff   <= ~mem_ff[addr_inc][7];
              end else begin
                // no acknowledge, keep the line released.
                st_ff <= tweei_pkg::ST_IGNORE;
              end
            end
            default: st_ff <= tweei_pkg::ST_IDLE;
          endcase
        end
      end
    end
  end
  assign sda_out    = 1'h0;
  assign sda_oe_out = oe_ff;

  // ----------------------------------------------------------------------
  // Page buffer and rewrite request
  // ----------------------------------------------------------------------
  // Data waits here until the rewrite ends; only then the array changes.
  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      pval_ff    <= '0;
      wrote_ff   <= 1'h0;
      pend_ff    <= 1'h0;
      req_tgl_ff <= 1'h0;
    end else if (lce) begin
      if (slot_end && st_ff == tweei_pkg::ST_DEVADR && give_ack &&
          !sh_ff[tweei_pkg::RW_POS]) begin
        pval_ff  <= '0;
        wrote_ff <= 1'h0;
      end else if (byte_end && st_ff == tweei_pkg::ST_WRDATA) begin
        // a later byte overwrites the same location.
        pbuf_ff[addr_ff[PAGE_W-1:0]] <= sh_ff;
        pval_ff[addr_ff[PAGE_W-1:0]] <= 1'h1;
        wrote_ff                     <= 1'h1;
      end
      // stop after data closes input and starts the rewrite.
      if (stop_det && st_ff == tweei_pkg::ST_WRDATA && wrote_ff) begin
        pend_ff    <= 1'h1;
        req_tgl_ff <= ~req_tgl_ff;
        wrote_ff   <= 1'h0;
      end else if (done_edge) begin
        pend_ff <= 1'h0;
      end
    end
  end

  // The array is plain storage and holds no reset value.
  always_ff @(posedge link_clk_in) begin
    if (lce && done_edge) begin
      for (int i = 0; i < PAGE; i++) begin
        if (pval_ff[i]) begin
          mem_ff[{addr_ff[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= pbuf_ff[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Rewrite timer in the system domain
  // ----------------------------------------------------------------------
  logic [2:0]    req_s_ff;
  logic          busy_ff;
  logic [CW-1:0] tmr_ff;

  // The request toggle is synchronised; its edge starts the timer.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      req_s_ff    <= 3'h0;
      busy_ff     <= 1'h0;
      tmr_ff      <= '0;
      done_tgl_ff <= 1'h0;
    end else if (ce_in) begin
      req_s_ff <= {req_s_ff[1:0], req_tgl_ff};
      if (req_s_ff[2] ^ req_s_ff[1]) begin
        busy_ff <= 1'h1;
        tmr_ff  <= '0;
      end else if (busy_ff) begin
        if (tmr_ff == CW'(REWRITE_CYC - 1)) begin
          busy_ff     <= 1'h0;
          done_tgl_ff <= ~done_tgl_ff;
        end else begin
          tmr_ff <= tmr_ff + 1'h1;
        end
      end
    end
  end
  assign busy_out = busy_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_rd_acked;
    st_ff == tweei_pkg::ST_RDDATA && slot_end && hack_ff;
  endsequence
  sequence s_rd_nacked;
    st_ff == tweei_pkg::ST_RDDATA && slot_end && !hack_ff;
  endsequence

  AST_START: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    lce && start_det |=> st_ff == tweei_pkg::ST_DEVADR && !oe_ff)
    else $error("start not taken");
  AST_STOP: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    lce && stop_det && !start_det |=> st_ff == tweei_pkg::ST_IDLE)
    else $error("stop not taken");
  AST_RD_STOP: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    lce && stop_det && st_ff == tweei_pkg::ST_RDDATA |=> !oe_ff)
    else $error("read not ended by stop");
  AST_WR_STOP: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    lce && stop_det && st_ff == tweei_pkg::ST_WRDATA && wrote_ff
    |=> pend_ff && $changed(req_tgl_ff))
    else $error("rewrite not started");
  AST_WR_ACK: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    lce && byte_end && (st_ff == tweei_pkg::ST_MEMADR ||
    st_ff == tweei_pkg::ST_WRDATA) |=> oe_ff && ack_ph_ff)
    else $error("missing acknowledge");
  AST_RD_REL: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    st_ff == tweei_pkg::ST_RDDATA && ack_ph_ff |-> !oe_ff)
    else $error("line held in host slot");
  AST_RD_NEXT: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (lce && !start_det && !stop_det) and s_rd_acked
    |=> addr_ff == $past(addr_inc) && sh_ff == mem_ff[addr_ff])
    else $error("read address not advanced");
  AST_NACK_REL: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (lce && !start_det && !stop_det) and s_rd_nacked
    |=> st_ff == tweei_pkg::ST_IGNORE && !oe_ff)
    else $error("line not released");
  AST_BUSY_NACK: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    lce && byte_end && st_ff == tweei_pkg::ST_DEVADR && pend_ff
    |=> !oe_ff && st_ff == tweei_pkg::ST_IGNORE)
    else $error("busy memory acknowledged");
  AST_WRAP: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    lce && slot_end && st_ff == tweei_pkg::ST_WRDATA && !start_det &&
    !stop_det |=> addr_ff[PAGE_W-1:0] == $past(addr_ff[PAGE_W-1:0]) + 1'h1)
    else $error("in-page offset wrong");
  AST_STABLE: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    $changed(oe_ff) && !$past(start_det) && !$past(stop_det)
    |-> !pin_d_ff.scl)
    else $error("data moved while clock high");
  AST_TIMER: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    $rose(busy_ff) |-> busy_ff [*8])
    else $error("rewrite ended early");
endmodule

// [tweei_core_bench.sv]
// Self-checking bench of the two-wire serial memory slave.
`timescale 1ns/1ns
module tweei_core_bench;
  // --------------------
  // Settings and signals
  // --------------------
  localparam int         REW   = 4000;  // Shortened rewrite time.
  localparam logic [3:0] DTYPE = 4'h6;  // Arbitrary type code.
  localparam int         LIMIT = 90000;
  logic       mclk_in;
  logic       link_clk;
  logic       rstn;
  logic [2:0] sel;
  logic       scl;
  logic       sda;
  logic       oe;
  logic       sda_val;
  logic       busy;
  logic       res_valid;
  logic [7:0] res;
  logic [7:0] exp_q[$];
  string      name_q[$];
  logic [7:0] dat[5];
  int         err_count;
  int         n_tests;
  int         hi_cnt;
  int         n_rew;
  int         seed;
  // --------------------
  // Clocks and parts
  // --------------------
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  // Link clock has its own phase so crossings are exercised.
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end
  tweei_core #(.REWRITE_CYC(REW), .TYPE_CODE(DTYPE)) uut (
    .mclk_in(mclk_in), .rstn_in(rstn), .ce_in(1'b1),
    .link_clk_in(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_val), .sda_oe_out(oe), .chip_select_bit2_in(sel[2]),
    .chip_select_bit1_in(sel[1]), .chip_select_bit0_in(sel[0]),
    .busy_out(busy));
  tweei_host host (.mclk_in(mclk_in), .dev_oe_in(oe), .scl_out(scl),
    .sda_out(sda), .res_valid_out(res_valid), .res_out(res));
  // --------------------
  // Checking
  // --------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Each slot result is matched to the oldest note; busy length too.
  always @(posedge mclk_in) begin
    if (res_valid === 1'b1) begin
      check(name_q.pop_front(), res, exp_q.pop_front());
    end
    if (busy === 1'b1) begin
      hi_cnt++;
    end else if (hi_cnt > 0) begin
      check("rewrite_len", hi_cnt > REW - 4 && hi_cnt < REW + 4, 1);
      hi_cnt = 0;
      n_rew++;
    end
  end
  // A hang is cut short after the expected run length.
  initial begin
    repeat (LIMIT) @(posedge mclk_in);
    err_count++;
    conclude();
  end
  // --------------------
  // Host actions
  // --------------------
  task automatic note(input string what, input logic [7:0] v);
    name_q.push_back(what);
    exp_q.push_back(v);
  endtask
  task automatic word(input logic [3:0] ty, input logic [2:0] cs,
                      input logic rw, input logic ack);
    note("word_ack", {7'h00, ack});
    host.start();
    host.xfer({ty, cs, rw}, 1'b1, 1'b0);
  endtask
  task automatic wr(input logic [7:0] d);
    note("write_ack", 8'h00);
    host.xfer(d, 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [7:0] d, input logic ack);
    note("read_data", d);
    host.xfer(8'hFF, ack, 1'b1);
  endtask
  // Dummy write loads the address, then a read word follows.
  task automatic set_addr(input logic [7:0] a);
    word(DTYPE, sel, 1'b0, 1'b0);
    wr(a);
    host.stop();
    word(DTYPE, sel, 1'b1, 1'b0);
  endtask
  // Bounded wait for the busy flag to reach a level.
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 8000) begin
      @(negedge mclk_in);
      n++;
    end
    check("busy_level", busy, lvl);
  endtask
  // --------------------
  // Main sequence
  // --------------------
  initial begin
    seed = 84;
    rstn = 1'b0;
    sel = 3'($random(seed));
    for (int i = 0; i < 5; i++) dat[i] = 8'($random(seed));
    repeat (5) @(negedge mclk_in);
    check("oe_reset", oe, 1'b0);
    check("busy_reset", busy, 1'b0);
    rstn = 1'b1;
    repeat (100) @(negedge mclk_in);
    word(DTYPE ^ 4'h1, sel, 1'b0, 1'b1);
    word(DTYPE, sel ^ 3'h4, 1'b1, 1'b1);
    host.stop();
    word(DTYPE, sel, 1'b0, 1'b0);
    wr(8'h1E);
    for (int i = 0; i < 4; i++) wr(dat[i]);
    host.stop();
    wait_busy(1'b1);
    word(DTYPE, sel, 1'b1, 1'b1);
    word(DTYPE, sel, 1'b0, 1'b1);
    host.stop();
    wait_busy(1'b0);
    word(DTYPE, sel, 1'b0, 1'b0);
    wr(8'hFF);
    wr(dat[4]);
    host.stop();
    wait_busy(1'b1);
    wait_busy(1'b0);
    set_addr(8'hFF);
    rd(dat[4], 1'b0);
    rd(dat[2], 1'b0);
    rd(dat[3], 1'b1);
    host.stop();
    set_addr(8'h1E);
    rd(dat[0], 1'b0);
    rd(dat[1], 1'b1);
    rd(8'hFF, 1'b1);
    host.stop();
    check("rewrites", n_rew, 2);
    check("sda_value", sda_val, 1'b0);
    conclude();
  end
endmodule

// [tweei_host.sv]
// Behavioural host that bit-bangs the two-wire memory bus.
`timescale 1ns/1ns
module tweei_host #(
  parameter int HALF = 64
) (
  // Timing reference and device drive.
  input  wire logic       mclk_in,
  input  wire logic       dev_oe_in,
  // Wire levels.
  output logic            scl_out,
  output wire logic       sda_out,
  // Result of each byte slot.
  output logic            res_valid_out,
  output logic [7:0]      res_out
);
  logic pull;
  // The line has a pull-up, so a released line reads high.
  assign sda_out = ~(pull | dev_oe_in);
  // Idle bus: both lines high.
  initial begin
    scl_out = 1'b1;
    pull = 1'b0;
    res_valid_out = 1'b0;
    res_out = 8'h00;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic bit_io(input logic b, output logic r);
    pull = ~b;
    wt(HALF);
    scl_out = 1'b1;
    wt(HALF / 2);
    r = sda_out;
    wt(HALF / 2);
    scl_out = 1'b0;
  endtask
  task automatic start();
    pull = 1'b0;
    wt(HALF);
    scl_out = 1'b1;
    wt(HALF);
    pull = 1'b1;
    wt(HALF);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    pull = 1'b1;
    wt(HALF);
    scl_out = 1'b1;
    wt(HALF);
    pull = 1'b0;
    wt(HALF);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack,
                      input logic want_data);
    logic [7:0] rx;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      rx = {rx[6:0], r};
    end
    bit_io(ack, r);
    res_out = want_data ? rx : {7'h00, r};
    res_valid_out = 1'b1;
    wt(1);
    res_valid_out = 1'b0;
  endtask
endmodule

// [tweei_pkg.sv]
// Shared constants and types of the two-wire serial memory slave.
package tweei_pkg;
  // ----------------------------------------------------------------------
  // Timing and counts
  // ----------------------------------------------------------------------
  localparam int         REWRITE_TIME_US = 10000;  // Longest rewrite time.
  localparam int         MCLK_MHZ        = 50;
  localparam int         REWRITE_CYCLES  = REWRITE_TIME_US * MCLK_MHZ;
  localparam logic [3:0] BIT_LAST        = 4'h8;   // Bits in one group.
  localparam logic [3:0] TYPE_CODE_DFLT  = 4'h5;   // Arbitrary value.
  // ----------------------------------------------------------------------
  // Field positions of the device address word
  // ----------------------------------------------------------------------
  localparam int         RW_POS          = 0;
  localparam int         SEL_LSB         = 1;
  localparam int         TYPE_LSB        = 4;
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DEVADR = 3'b001,
    ST_MEMADR = 3'b010,
    ST_WRDATA = 3'b011,
    ST_RDDATA = 3'b100,
    ST_IGNORE = 3'b101
  } tweei_state_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } tweei_pins_t;
endpackage
